// ==== design/fpd_core.sv ====
`timescale 1ns/10ps
`include "fpd_params.svh"
module fpd_core
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Request.
  input wire logic i_req_valid,
  input wire fpd_pkg::fpd_req_t i_req,
  output logic o_req_ready,
  // Answer.
  output logic o_done,
  output fpd_pkg::fpd_res_t o_res
);

  // ===========================================================================
  // Format helpers
  function automatic logic signed [17:0] fpd_emin(input fpd_pkg::fpd_fmt_t f);
    unique case (f)
      fpd_pkg::FPD_FMT_SGL: return `FPD_EMIN_SGL;
      fpd_pkg::FPD_FMT_DBL: return `FPD_EMIN_DBL;
      default: return `FPD_EMIN_EXT;
    endcase
  endfunction
  function automatic logic signed [17:0] fpd_bias(input fpd_pkg::fpd_fmt_t f);
    unique case (f)
      fpd_pkg::FPD_FMT_SGL: return `FPD_BIAS_SGL;
      fpd_pkg::FPD_FMT_DBL: return `FPD_BIAS_DBL;
      default: return `FPD_BIAS_EXT;
    endcase
  endfunction
  function automatic logic [6:0] fpd_lsb(input fpd_pkg::fpd_fmt_t f);
    unique case (f)
      fpd_pkg::FPD_FMT_SGL: return `FPD_LSB_SGL;
      fpd_pkg::FPD_FMT_DBL: return `FPD_LSB_DBL;
      default: return `FPD_LSB_EXT;
    endcase
  endfunction
  // The integer bit is dropped for the narrow formats and kept for extended.
  function automatic logic [79:0] fpd_pack(input logic s, input logic [14:0] be, input logic [63:0] sg,
                                           input fpd_pkg::fpd_fmt_t f);
    unique case (f)
      fpd_pkg::FPD_FMT_SGL: return {48'h0, s, be[7:0], sg[62:40]};
      fpd_pkg::FPD_FMT_DBL: return {16'h0, s, be[10:0], sg[62:11]};
      default: return {s, be, sg};
    endcase
  endfunction
  function automatic logic [14:0] fpd_bexp(input logic [79:0] v, input fpd_pkg::fpd_fmt_t f);
    unique case (f)
      fpd_pkg::FPD_FMT_SGL: return {7'h0, v[30:23]};
      fpd_pkg::FPD_FMT_DBL: return {4'h0, v[62:52]};
      default: return v[78:64];
    endcase
  endfunction
  // Rounds the working word at the destination precision; bit 64 is the carry out.
  function automatic logic [64:0] fpd_round(input logic [66:0] w, input fpd_pkg::fpd_fmt_t f,
                                            input fpd_pkg::fpd_rnd_t m, input logic s);
    logic [6:0] l;
    logic g;
    logic st;
    logic inc;
    logic [63:0] sg;
    l = fpd_lsb(f);
    g = w[l + 7'h02];
    st = 1'b0;
    for (int i = 0; i < 67; i++)
      if (i < int'(l) + 2) st = st | w[i];
    sg = w[66:3];
    for (int i = 0; i < 64; i++)
      if (i < int'(l)) sg[i] = 1'b0;
    unique case (m)
      fpd_pkg::FPD_RND_NEAR: inc = g & (st | w[l + 7'h03]);
      fpd_pkg::FPD_RND_DOWN: inc = s & (g | st);
      fpd_pkg::FPD_RND_UP: inc = ~s & (g | st);
      fpd_pkg::FPD_RND_CHOP: inc = 1'b0;
    endcase
    return {1'b0, sg} + (inc ? (65'h1 << l) : 65'h0);
  endfunction

  // ===========================================================================
  // Sequencer
  typedef enum logic [3:0] {
    FPD_ST_IDLE = 4'h1,
    FPD_ST_DENORM = 4'h2,
    FPD_ST_NORM = 4'h4,
    FPD_ST_ROUND = 4'h8
  } fpd_state_t;
  fpd_state_t state_q, state_d;
  fpd_pkg::fpd_req_t req_q, req_d;
  logic signed [17:0] exp_q, exp_d;
  logic [66:0] w_q, w_d;
  fpd_pkg::fpd_res_t res_q, res_d;
  logic done_q, done_d;
  logic ready_q, ready_d;
  logic accept;
  fpd_pkg::fpd_fmt_t dfmt;
  logic signed [17:0] u_exp;
  logic [63:0] u_sig;
  logic src_den;
  logic [64:0] rnd;
  logic [63:0] r_sig;
  logic signed [17:0] r_exp;
  logic [14:0] r_be;
  logic [17:0] be_sum;
  assign accept = i_req_valid & ready_q;
  // Source operands are always widened to extended.
  assign dfmt = req_q.is_src ? fpd_pkg::FPD_FMT_EXT : req_q.fmt;
  always_comb
  begin
    u_exp = `FPD_EMIN_EXT;
    u_sig = i_req.raw[63:0];
    src_den = 1'b0;
    unique case (i_req.fmt)
      fpd_pkg::FPD_FMT_SGL:
      begin
        u_sig = {i_req.raw[30:23] != 8'h0, i_req.raw[22:0], 40'h0};
        u_exp = (i_req.raw[30:23] == 8'h0) ? `FPD_EMIN_SGL : $signed({10'h0, i_req.raw[30:23]}) - `FPD_BIAS_SGL;
        src_den = (i_req.raw[30:23] == 8'h0) && (i_req.raw[22:0] != 23'h0);
      end
      fpd_pkg::FPD_FMT_DBL:
      begin
        u_sig = {i_req.raw[62:52] != 11'h0, i_req.raw[51:0], 11'h0};
        u_exp = (i_req.raw[62:52] == 11'h0) ? `FPD_EMIN_DBL : $signed({7'h0, i_req.raw[62:52]}) - `FPD_BIAS_DBL;
        src_den = (i_req.raw[62:52] == 11'h0) && (i_req.raw[51:0] != 52'h0);
      end
      default:
      begin
        u_exp = (i_req.raw[78:64] == 15'h0) ? `FPD_EMIN_EXT : $signed({3'h0, i_req.raw[78:64]}) - `FPD_BIAS_EXT;
        src_den = (i_req.raw[78:64] == 15'h0) && (i_req.raw[63:0] != 64'h0);
      end
    endcase
  end
  always_comb
  begin
    rnd = fpd_round(w_q, dfmt, req_q.rnd, req_q.sign);
    r_sig = rnd[64] ? {1'b1, rnd[63:1]} : rnd[63:0];
    r_exp = rnd[64] ? exp_q + 18'sh1 : exp_q;
    be_sum = 18'(r_exp + fpd_bias(dfmt));
    // A zero integer bit encodes a zero exponent field, which covers denormals and zeros.
    r_be = r_sig[63] ? be_sum[14:0] : 15'h0;
  end
  always_comb
  begin
    state_d = state_q;
    req_d = req_q;
    exp_d = exp_q;
    w_d = w_q;
    res_d = res_q;
    done_d = 1'b0;
    unique case (state_q)
      FPD_ST_IDLE:
      begin
        if (accept)
        begin
          req_d = i_req;
          res_d = '0;
          if (i_req.is_src)
          begin
            exp_d = u_exp;
            w_d = {u_sig, 3'h0};
            res_d.de = i_req.arith & src_den;
            if (i_req.arith & src_den & ~i_req.de_mask)
            begin
              res_d.trap = 1'b1;
              done_d = 1'b1;
            end
            else if (src_den && i_req.fmt != fpd_pkg::FPD_FMT_EXT)
              state_d = FPD_ST_NORM;
            else
              state_d = FPD_ST_ROUND;
          end
          else if (!i_req.arith)
          begin
            // Moves that are not sources pass the value untouched; only the tag is derived.
            res_d.value = i_req.raw;
            res_d.tag = (fpd_bexp(i_req.raw, i_req.fmt) != 15'h0) ? `FPD_TAG_VALID :
                        (u_sig == 64'h0) ? `FPD_TAG_ZERO : `FPD_TAG_SPECIAL;
            done_d = 1'b1;
          end
          else
          begin
            exp_d = i_req.exp;
            w_d = {i_req.sig, i_req.grs};
            if ((i_req.sig != 64'h0) && (i_req.exp < fpd_emin(i_req.fmt)))
            begin
              res_d.uf = 1'b1;
              if (!i_req.uf_mask)
              begin
                res_d.trap = 1'b1;
                done_d = 1'b1;
              end
              else
                state_d = FPD_ST_DENORM;
            end
            else
              state_d = FPD_ST_ROUND;
          end
        end
      end
      FPD_ST_DENORM:
      begin
        if (exp_q == fpd_emin(dfmt))
          state_d = FPD_ST_ROUND;
        else if (w_q[66:3] == 64'h0)
        begin
          // Everything shifted out; the remainder only feeds the sticky bit.
          w_d = {64'h0, 2'h0, |w_q[2:0]};
          exp_d = fpd_emin(dfmt);
          state_d = FPD_ST_ROUND;
        end
        else
        begin
          w_d = {1'b0, w_q[66:2], w_q[1] | w_q[0]};
          exp_d = exp_q + 18'sh1;
        end
      end
      FPD_ST_NORM:
      begin
        if (w_q[66])
          state_d = FPD_ST_ROUND;
        else
        begin
          w_d = {w_q[65:0], 1'b0};
          exp_d = exp_q - 18'sh1;
        end
      end
      FPD_ST_ROUND:
      begin
        res_d.value = fpd_pack(req_q.sign & ~req_q.is_src | req_q.is_src & req_q.raw[fpd_lsb(req_q.fmt) == 7'h28 ?
                               31 : (req_q.fmt == fpd_pkg::FPD_FMT_DBL ? 63 : 79)], r_be, r_sig, dfmt);
        res_d.tag = (r_sig == 64'h0) ? `FPD_TAG_ZERO :
                    r_sig[63] ? `FPD_TAG_VALID : `FPD_TAG_SPECIAL;
        done_d = 1'b1;
        state_d = FPD_ST_IDLE;
      end
    endcase
    ready_d = (state_d == FPD_ST_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= FPD_ST_IDLE;
      req_q <= '0;
      exp_q <= '0;
      w_q <= '0;
      res_q <= '0;
      done_q <= 1'b0;
      ready_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      req_q <= req_d;
      exp_q <= exp_d;
      w_q <= w_d;
      res_q <= res_d;
      done_q <= done_d;
      ready_q <= ready_d;
    end
  end
  assign o_req_ready = ready_q;
  assign o_done = done_q;
  assign o_res = res_q;
  // ===========================================================================
  // Assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_tiny_traps: assert property (accept && !i_req.is_src && i_req.arith && i_req.sig != 64'h0 && !i_req.uf_mask &&
    i_req.exp < fpd_emin(i_req.fmt) |=> o_done && o_res.trap && o_res.uf) else $error("unmasked tiny result did not trap");
  a_denorm_encode: assert property (o_done && !o_res.trap && o_res.tag == `FPD_TAG_SPECIAL
    |-> fpd_bexp(o_res.value, dfmt) == 15'h0) else $error("denormal exponent field not zero");
  a_zero_tagged: assert property (o_done && !o_res.trap && req_q.arith && o_res.tag == `FPD_TAG_ZERO
    |-> o_res.value[62:0] == 63'h0) else $error("zero tag on nonzero significand");
  a_src_de_trap: assert property (accept && i_req.is_src && i_req.arith && src_den && !i_req.de_mask
    |=> o_done && o_res.de && o_res.trap) else $error("denormal source did not trap");
  a_src_normal: assert property (o_done && req_q.is_src && o_res.de && !o_res.trap && req_q.fmt != fpd_pkg::FPD_FMT_EXT
    |-> o_res.value[63] && o_res.tag == `FPD_TAG_VALID) else $error("narrow denormal source not normalized");
  a_denorm_step: assert property (state_q == FPD_ST_DENORM && exp_q != fpd_emin(dfmt) && w_q[66:3] != 64'h0
    |=> exp_q == $past(exp_q) + 18'sh1 && w_q[65:2] == $past(w_q[66:3])) else $error("denormal step wrong");
  a_move_pass: assert property (accept && !i_req.is_src && !i_req.arith
    |=> o_done && o_res.value == $past(i_req.raw) && !o_res.uf) else $error("move altered its operand");
  a_normal_out: assert property (o_done && !o_res.trap && req_q.arith && o_res.tag == `FPD_TAG_VALID
    |-> fpd_bexp(o_res.value, dfmt) != 15'h0) else $error("valid result with zero exponent");
  a_arith_done: assert property (accept && i_req.arith |-> ##[1:80] o_done) else $error("no answer in time");

  c_denorm: cover property (o_done && o_res.uf && o_res.tag == `FPD_TAG_SPECIAL);
  c_flush_zero: cover property (o_done && o_res.uf && o_res.tag == `FPD_TAG_ZERO);
  c_src_norm: cover property (state_q == FPD_ST_NORM ##1 state_q == FPD_ST_NORM);
  c_trap: cover property (o_done && o_res.trap);

endmodule // fpd_core

// ==== design/fpd_params.svh ====
// Function
// - Instructions with no operands or that move operands unchanged are nonarithmetic; all others are arithmetic.
// - A nonzero result is tiny when its magnitude is below two to the destination minimum exponent (-126, -1022, -16382).
// - Normalized values have an integer bit of one, stored only in extended and implied in single and double.
// - A denormal has a biased exponent of zero and an integer bit of zero.
// - Denormals and zeros share the zero exponent and are told apart by a nonzero or all-zero significand.
// - Results are always normalized except when tiny for their destination.
// - A tiny result is denormalized by shifting right one place and bumping the exponent until it reaches the minimum.
// - Denormalization works for single, double and extended destinations, registers and memory alike.
// - A denormal held in a stack register is tagged special.
// - When every significand bit is shifted out the result is a true zero and is tagged zero;
//   the code keeps a sticky bit, so rounding away from zero gives the smallest denormal.
// - Underflow is raised whenever a result would be denormalized, and traps when unmasked.
// - The denormal exception is raised whenever a denormal enters a calculation as a source operand.
// - With underflow masked a tiny result delivers the denormal or zero instead of trapping.
// - With the denormal exception masked a single or double denormal source is normalized on widening.
// - Single and double values are widened to extended for internal use and may be narrowed for stores.
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH
`define FPD_EMIN_SGL (-18'sh7E)
`define FPD_EMIN_DBL (-18'sh3FE)
`define FPD_EMIN_EXT (-18'sh3FFE)
`define FPD_BIAS_SGL 18'sh7F
`define FPD_BIAS_DBL 18'sh3FF
`define FPD_BIAS_EXT 18'sh3FFF
`define FPD_LSB_SGL 7'h28
`define FPD_LSB_DBL 7'h0B
`define FPD_LSB_EXT 7'h00
`define FPD_TAG_VALID 2'h0
`define FPD_TAG_ZERO 2'h1
`define FPD_TAG_SPECIAL 2'h2
`define FPD_TAG_EMPTY 2'h3
`endif

// ==== design/fpd_pkg.sv ====
package fpd_pkg;
  typedef enum logic [1:0] {FPD_FMT_SGL = 2'h0, FPD_FMT_DBL = 2'h1, FPD_FMT_EXT = 2'h2} fpd_fmt_t;
  typedef enum logic [1:0] {FPD_RND_NEAR = 2'h0, FPD_RND_DOWN = 2'h1, FPD_RND_UP = 2'h2, FPD_RND_CHOP = 2'h3} fpd_rnd_t;
  typedef struct packed {
    logic is_src;
    logic arith;
    fpd_fmt_t fmt;
    fpd_rnd_t rnd;
    logic uf_mask;
    logic de_mask;
    logic sign;
    logic signed [17:0] exp;
    logic [63:0] sig;
    logic [2:0] grs;
    logic [79:0] raw;
  } fpd_req_t;
  typedef struct packed {
    logic [79:0] value;
    logic [1:0] tag;
    logic uf;
    logic de;
    logic trap;
  } fpd_res_t;
endpackage

// ==== verif/test_fpd_core.sv ====
`timescale 1ns/10ps
module test_fpd_core;
  logic i_clk;
  logic i_rst_b;
  logic i_req_valid;
  fpd_pkg::fpd_req_t i_req;
  logic o_req_ready;
  logic o_done;
  fpd_pkg::fpd_res_t o_res;
  int error_cnt;
  int n_checks;
  logic [1:0] mode;

  fpd_core u_fpd_core
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_req_valid(i_req_valid),
    .i_req(i_req),
    .o_req_ready(o_req_ready),
    .o_done(o_done),
    .o_res(o_res)
  );

  always #5 i_clk = ~i_clk;

  // ==========================================
  // Shared tasks.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string what, logic [79:0] e, logic [79:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic fpd_pkg::fpd_req_t mk(logic src, logic ar, fpd_pkg::fpd_fmt_t f, logic [1:0] m, logic um,
                                           logic dm, logic signed [17:0] e, logic [63:0] s, logic [79:0] raw);
    fpd_pkg::fpd_req_t r;
    r = '0;
    r.is_src = src;
    r.arith = ar;
    r.fmt = f;
    r.rnd = fpd_pkg::fpd_rnd_t'(m);
    r.uf_mask = um;
    r.de_mask = dm;
    r.exp = e;
    r.sig = s;
    r.raw = raw;
    return r;
  endfunction

  // A busy request is offered mid-operation when junk is set; it must leave no trace.
  task automatic run(fpd_pkg::fpd_req_t r, logic junk);
    int n;
    int extra;
    @(posedge i_clk);
    i_req <= r;
    i_req_valid <= 1'b1;
    n = 0;
    #1;
    // Ready only moves on an edge, so the value seen here is what the next edge takes.
    while (o_req_ready !== 1'b1)
    begin
      if (n == 50)
      begin
        error_cnt++;
        $display("wrong value ready expected 1 seen timeout");
        results();
      end
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    #1;
    n = 0;
    while (o_done !== 1'b1)
    begin
      if (n == 200)
      begin
        error_cnt++;
        $display("wrong value done expected 1 seen timeout");
        results();
      end
      @(posedge i_clk);
      if (junk && n < 2)
      begin
        i_req_valid <= (n == 0);
        i_req <= mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b1, 18'sh0, 64'hC000000000000000, 80'h0);
      end
      #1;
      n++;
    end
    chk("ready at done", 80'h1, 80'(o_req_ready));
    if (junk)
    begin
      extra = 0;
      repeat (8)
      begin
        @(posedge i_clk);
        #1;
        extra += (o_done === 1'b1);
      end
      chk("extra done", 80'h0, 80'(extra));
    end
  endtask

  task automatic expect_res(logic [79:0] v, logic [1:0] t, logic uf, logic de, logic tr);
    chk("value", v, o_res.value);
    chk("tag", 80'(t), 80'(o_res.tag));
    chk("uf", 80'(uf), 80'(o_res.uf));
    chk("de", 80'(de), 80'(o_res.de));
    chk("trap", 80'(tr), 80'(o_res.trap));
  endtask

  // ==========================================
  // Scenarios.
  task automatic t_results();
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b1, 18'sh0, 64'h8000000000000000, 80'h0), 1'b0);
    expect_res(80'h3F800000, 2'h0, 1'b0, 1'b0, 1'b0);
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b1, -18'sh7E, 64'h8000000000000000, 80'h0), 1'b0);
    expect_res(80'h00800000, 2'h0, 1'b0, 1'b0, 1'b0);
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b1, -18'sh81, 64'hAE00000000000000, 80'h0), 1'b1);
    expect_res(80'h0015C000, 2'h2, 1'b1, 1'b0, 1'b0);
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b0, 1'b1, -18'sh81, 64'hAE00000000000000, 80'h0), 1'b0);
    expect_res(80'h0, 2'h0, 1'b1, 1'b0, 1'b1);
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h3, 1'b1, 1'b1, -18'shC4, 64'h8000000000000000, 80'h0), 1'b0);
    expect_res(80'h0, 2'h1, 1'b1, 1'b0, 1'b0);
    $display("test results done");
  endtask

  task automatic t_formats();
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_DBL, 2'h0, 1'b1, 1'b1, -18'sh3FF, 64'h8000000000000000, 80'h0), 1'b0);
    expect_res(80'h0008000000000000, 2'h2, 1'b1, 1'b0, 1'b0);
    run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_EXT, 2'h0, 1'b1, 1'b1, -18'sh3FFF, 64'h8000000000000000, 80'h0), 1'b0);
    expect_res(80'h00004000000000000000, 2'h2, 1'b1, 1'b0, 1'b0);
    $display("test formats done");
  endtask

  task automatic t_round();
    logic [79:0] want [4];
    logic [79:0] want_neg [4];
    fpd_pkg::fpd_req_t r;
    want = '{80'h2, 80'h1, 80'h2, 80'h1};
    want_neg = '{80'h80000002, 80'h80000002, 80'h80000001, 80'h80000001};
    for (int i = 0; i < 4; i++)
    begin
      mode = 2'(i);
      run(mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, mode, 1'b1, 1'b1, -18'sh95, 64'hC000000000000000, 80'h0), 1'b0);
      expect_res(want[i], 2'h2, 1'b1, 1'b0, 1'b0);
      r = mk(1'b0, 1'b1, fpd_pkg::FPD_FMT_SGL, mode, 1'b1, 1'b1, -18'sh95, 64'hC000000000000000, 80'h0);
      r.sign = 1'b1;
      run(r, 1'b0);
      expect_res(want_neg[i], 2'h2, 1'b1, 1'b0, 1'b0);
    end
    $display("test round done");
  endtask

  task automatic t_sources();
    run(mk(1'b1, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b1, 18'sh0, 64'h0, 80'h00400000), 1'b0);
    expect_res(80'h3F808000000000000000, 2'h0, 1'b0, 1'b1, 1'b0);
    run(mk(1'b1, 1'b1, fpd_pkg::FPD_FMT_DBL, 2'h0, 1'b1, 1'b1, 18'sh0, 64'h0, 80'h0008000000000000), 1'b0);
    expect_res(80'h3C008000000000000000, 2'h0, 1'b0, 1'b1, 1'b0);
    run(mk(1'b1, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b0, 18'sh0, 64'h0, 80'h00400000), 1'b0);
    expect_res(80'h0, 2'h0, 1'b0, 1'b1, 1'b1);
    run(mk(1'b1, 1'b1, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b1, 18'sh0, 64'h0, 80'h3F800000), 1'b0);
    expect_res(80'h3FFF8000000000000000, 2'h0, 1'b0, 1'b0, 1'b0);
    run(mk(1'b1, 1'b1, fpd_pkg::FPD_FMT_EXT, 2'h0, 1'b1, 1'b1, 18'sh0, 64'h0, 80'h00004000000000000000), 1'b0);
    chk("ext src value", 80'h00004000000000000000, o_res.value);
    chk("ext src de", 80'h1, 80'(o_res.de));
    $display("test sources done");
  endtask

  task automatic t_moves();
    run(mk(1'b0, 1'b0, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b0, 1'b0, -18'shC4, 64'h8000000000000000, 80'h00400000), 1'b0);
    chk("move value", 80'h00400000, o_res.value);
    chk("move uf", 80'h0, 80'(o_res.uf));
    chk("move trap", 80'h0, 80'(o_res.trap));
    run(mk(1'b1, 1'b0, fpd_pkg::FPD_FMT_SGL, 2'h0, 1'b1, 1'b0, 18'sh0, 64'h0, 80'h00400000), 1'b0);
    chk("move de", 80'h0, 80'(o_res.de));
    chk("move src trap", 80'h0, 80'(o_res.trap));
    $display("test moves done");
  endtask

  // ==========================================
  // Main sequence.
  initial
  begin
    i_clk = 1'b0;
    i_rst_b = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    mode = 2'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_results();
    t_formats();
    t_round();
    t_sources();
    t_moves();
    results();
  end
endmodule // test_fpd_core
